// ---- design/ssm_spi_mem.sv ----
// serial peripheral slave giving byte access to the nonvolatile array
`timescale 1ns/1ps
// What this block does
// - write address is two bytes, top bit ignored, fifteen bits used.
// - byte address advances after every data byte and wraps to zero.
// - data bytes move most significant bit first both ways.
// - each received data byte is stored at its eighth bit, unlimited.
// - chip select rising ends a write and drops any partial byte.
// - write protect is taken only at chip select falling.
// - read command then two address bytes, low fifteen bits used.
// - after read command and address the serial input is ignored.
// - read shifts one bit out per clock, byte every eight clocks.
// - chip select rising ends a read and returns to idle.
// - pause low with clock low freezes the transfer in place.
// - pause high with clock low resumes exactly where it stopped.
// - clock toggling while paused does not advance the transfer.
// - command codes are 06h latch, 02h write, 03h read, first byte.
// - finishing a write frame clears the write latch.
// - input taken on rising clock, output changed on falling clock.
// - bytes inside the block-protected range are not stored.
module ssm_spi_mem (
    // system clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // serial link pins
    input wire logic sck_i,
    input wire logic cs_n_i,
    input wire logic si_i,
    input wire logic hold_n_i,
    input wire logic wp_n_i,
    output logic so_o,
    output logic so_oe_n_o,
    // block protection setting from system logic
    input wire logic block_protect_hi_i,
    input wire logic block_protect_lo_i,
    // status
    output logic write_latch_flag_o
);

    // state on the serial clock rising edge
    typedef struct packed {
        ssm_pkg::ssm_phase_t phase;
        logic [2:0] bit_cnt;
        logic [7:0] in_shift;
        logic [ssm_pkg::ADDR_W-1:0] addr;
        logic is_read;
        logic is_write;
        logic latch_cmd_seen;
    } ssm_rise_t;

    // state on the serial clock falling edge
    typedef struct packed {
        logic [7:0] out_shift;
        logic driving;
    } ssm_fall_t;

    // state on the system clock
    typedef struct packed {
        logic cs_n_f;
        logic wp_n_f;
        logic frame_latch_cmd;
        logic frame_write;
        logic write_latch_flag;
        logic wp_n_cap;
        logic allow;
        logic [1:0] bp_cap;
    } ssm_sys_t;

    ssm_rise_t rise_reg;
    ssm_rise_t rise_next;
    ssm_fall_t fall_reg;
    ssm_fall_t fall_next;
    ssm_sys_t sys_reg;
    ssm_sys_t sys_next;

    logic [7:0] byte_in;
    logic byte_done;
    logic protected_hit;
    logic mem_we;
    logic mem_re;
    logic [ssm_pkg::ADDR_W-1:0] mem_raddr;
    logic [7:0] mem_rdata;
    logic [2:0] link_ctrl;
    logic [1:0] frame_flags;
    logic [1:0] pin_last;
    logic [1:0] pin_prev;
    logic link_allow;
    logic [1:0] link_bp;

    // pins entering the system clock domain, three stages each
    ssm_sync #(
        .W(2),
        .STAGES(ssm_pkg::PIN_SYNC_STAGES)
    ) u_pin_sync (
        .clk_i(clk_i),
        .clr_n_i(1'b1),
        .d_i({cs_n_i, wp_n_i}),
        .q_o(pin_last),
        .q_prev_o(pin_prev)
    );

    // per-frame command flags from the link domain
    ssm_sync #(
        .W(2),
        .STAGES(ssm_pkg::CDC_STAGES)
    ) u_flag_sync (
        .clk_i(clk_i),
        .clr_n_i(1'b1),
        .d_i({rise_reg.latch_cmd_seen, rise_reg.is_write}),
        .q_o(frame_flags),
        // first-stage tap left open: reading it would bypass the sync
        .q_prev_o()
    );

    // write permission and protect range into the link domain;
    // cleared while deselected so every frame starts from a safe value
    ssm_sync #(
        .W(3),
        .STAGES(ssm_pkg::CDC_STAGES)
    ) u_ctrl_sync (
        .clk_i(sck_i),
        .clr_n_i(~cs_n_i),
        .d_i({sys_reg.allow, sys_reg.bp_cap}),
        .q_o(link_ctrl),
        // same here: only the last stage may be read
        .q_prev_o()
    );

    assign link_allow = link_ctrl[2];
    assign link_bp = link_ctrl[1:0];

    // system domain: latch keeping and per-frame captures
    always_comb begin
        sys_next = sys_reg;
        // a pin change counts once the last two stages agree
        if (pin_last[1] == pin_prev[1]) begin
            sys_next.cs_n_f = pin_last[1];
        end
        if (pin_last[0] == pin_prev[0]) begin
            sys_next.wp_n_f = pin_last[0];
        end
        if (sys_reg.cs_n_f && !sys_next.cs_n_f) begin
            // frame start: protect state frozen for the whole frame
            sys_next.wp_n_cap = sys_reg.wp_n_f;
            sys_next.bp_cap = {block_protect_hi_i, block_protect_lo_i};
            sys_next.frame_latch_cmd = 1'b0;
            sys_next.frame_write = 1'b0;
        end else if (!sys_reg.cs_n_f) begin
            // sticky, because the link flags clear as the frame ends
            sys_next.frame_latch_cmd = sys_reg.frame_latch_cmd
                | frame_flags[1];
            sys_next.frame_write = sys_reg.frame_write | frame_flags[0];
        end
        if (!sys_reg.cs_n_f && sys_next.cs_n_f) begin
            if (sys_next.frame_write) begin
                sys_next.write_latch_flag = 1'b0;
            end else if (sys_next.frame_latch_cmd) begin
                sys_next.write_latch_flag = 1'b1;
            end
        end
        sys_next.allow = sys_next.write_latch_flag
            & sys_next.wp_n_cap;
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            sys_reg <= '0;
            sys_reg.cs_n_f <= ssm_pkg::PIN_HIGH_RST;
            sys_reg.wp_n_f <= ssm_pkg::PIN_HIGH_RST;
            sys_reg.write_latch_flag <= ssm_pkg::WRITE_LATCH_RST;
        end else begin
            sys_reg <= sys_next;
        end
    end

    // link domain, rising edge: command, address and data intake
    assign byte_in = {rise_reg.in_shift[6:0], si_i};
    assign byte_done = (rise_reg.bit_cnt == ssm_pkg::BIT_LAST);

    always_comb begin
        unique case (link_bp)
            ssm_pkg::PROT_NONE: protected_hit = 1'b0;
            ssm_pkg::PROT_QUARTER:
                protected_hit = rise_reg.addr >= ssm_pkg::PROT_QUARTER_BASE;
            ssm_pkg::PROT_HALF:
                protected_hit = rise_reg.addr >= ssm_pkg::PROT_HALF_BASE;
            ssm_pkg::PROT_ALL: protected_hit = 1'b1;
        endcase
    end

    // store at the eighth bit; a partial byte never reaches this point
    assign mem_we = hold_n_i && byte_done
        && (rise_reg.phase == ssm_pkg::SSM_WR_DATA)
        && link_allow && !protected_hit;

    // fetch the first byte as the address completes, then one ahead
    assign mem_re = hold_n_i && byte_done
        && (((rise_reg.phase == ssm_pkg::SSM_ADDR_LO) && rise_reg.is_read)
        || (rise_reg.phase == ssm_pkg::SSM_RD_DATA));
    assign mem_raddr = (rise_reg.phase == ssm_pkg::SSM_ADDR_LO)
        ? {rise_reg.addr[14:8], byte_in}
        : rise_reg.addr + ssm_pkg::ADDR_ONE;

    always_comb begin
        rise_next = rise_reg;
        // pause low at the rising edge holds every bit of state
        if (hold_n_i) begin
            rise_next.bit_cnt = rise_reg.bit_cnt + ssm_pkg::BIT_STEP;
            if (rise_reg.phase != ssm_pkg::SSM_RD_DATA) begin
                rise_next.in_shift = byte_in;
            end
            unique case (rise_reg.phase)
                ssm_pkg::SSM_CMD: begin
                    if (byte_done) begin
                        rise_next.phase = ssm_pkg::SSM_IGNORE;
                        if (byte_in == ssm_pkg::CMD_SET_WRITE_LATCH) begin
                            rise_next.latch_cmd_seen = 1'b1;
                        end else if (byte_in == ssm_pkg::CMD_WRITE) begin
                            rise_next.is_write = 1'b1;
                            rise_next.phase = ssm_pkg::SSM_ADDR_HI;
                        end else if (byte_in == ssm_pkg::CMD_READ) begin
                            rise_next.is_read = 1'b1;
                            rise_next.phase = ssm_pkg::SSM_ADDR_HI;
                        end
                    end
                end
                ssm_pkg::SSM_ADDR_HI: begin
                    if (byte_done) begin
                        // top address bit is dropped here
                        rise_next.addr[14:8] = byte_in[6:0];
                        rise_next.phase = ssm_pkg::SSM_ADDR_LO;
                    end
                end
                ssm_pkg::SSM_ADDR_LO: begin
                    if (byte_done) begin
                        rise_next.addr[7:0] = byte_in;
                        rise_next.phase = rise_reg.is_read
                            ? ssm_pkg::SSM_RD_DATA : ssm_pkg::SSM_WR_DATA;
                    end
                end
                ssm_pkg::SSM_WR_DATA, ssm_pkg::SSM_RD_DATA: begin
                    if (byte_done) begin
                        // fifteen-bit add wraps from the top back to zero
                        rise_next.addr = rise_reg.addr
                            + ssm_pkg::ADDR_ONE;
                    end
                end
                ssm_pkg::SSM_IGNORE: begin
                    rise_next.bit_cnt = rise_reg.bit_cnt;
                end
            endcase
        end
    end

    // deselect clears the frame at once, whatever the clock is doing
    always_ff @(posedge sck_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            rise_reg <= '0;
        end else begin
            rise_reg <= rise_next;
        end
    end

    ssm_mem u_mem (
        .clk_i(sck_i),
        .we_i(mem_we),
        .waddr_i(rise_reg.addr),
        .wdata_i(byte_in),
        .re_i(mem_re),
        .raddr_i(mem_raddr),
        .rdata_o(mem_rdata)
    );

    // link domain, falling edge: read data out
    always_comb begin
        fall_next = fall_reg;
        if (hold_n_i) begin
            fall_next.driving = (rise_reg.phase == ssm_pkg::SSM_RD_DATA);
            if (rise_reg.phase == ssm_pkg::SSM_RD_DATA) begin
                if (rise_reg.bit_cnt == ssm_pkg::BIT_FIRST) begin
                    fall_next.out_shift = mem_rdata;
                end else begin
                    fall_next.out_shift = {fall_reg.out_shift[6:0], 1'b0};
                end
            end
        end
    end

    always_ff @(negedge sck_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            fall_reg <= '0;
        end else begin
            fall_reg <= fall_next;
        end
    end

    // enable follows the pins directly so release is immediate
    assign so_o = fall_reg.out_shift[7];
    assign so_oe_n_o = cs_n_i | ~hold_n_i | ~fall_reg.driving;
    assign write_latch_flag_o = sys_reg.write_latch_flag;

endmodule : ssm_spi_mem

// ---- design/ssm_pkg.sv ----
// shared constants and types for the serial memory access block
package ssm_pkg;

    // memory geometry
    localparam int ADDR_W = 15;
    localparam int DATA_W = 8;
    localparam int MEM_DEPTH = 32768;

    // command byte encodings
    localparam logic [7:0] CMD_SET_WRITE_LATCH = 8'h06;
    localparam logic [7:0] CMD_WRITE = 8'h02;
    localparam logic [7:0] CMD_READ = 8'h03;

    // block protection bases and address limits
    localparam logic [14:0] PROT_QUARTER_BASE = 15'h6000;
    localparam logic [14:0] PROT_HALF_BASE = 15'h4000;
    localparam logic [14:0] ADDR_ONE = 15'h0001;
    localparam logic [1:0] PROT_NONE = 2'h0;
    localparam logic [1:0] PROT_QUARTER = 2'h1;
    localparam logic [1:0] PROT_HALF = 2'h2;
    localparam logic [1:0] PROT_ALL = 2'h3;

    // bit counter limits within one byte
    localparam logic [2:0] BIT_FIRST = 3'h0;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [2:0] BIT_STEP = 3'h1;

    // synchroniser depths
    localparam int PIN_SYNC_STAGES = 3;
    localparam int CDC_STAGES = 2;

    // reset values
    localparam logic WRITE_LATCH_RST = 1'b0;
    localparam logic PIN_HIGH_RST = 1'b1;

    // frame phases on the serial clock
    typedef enum logic [2:0] {
        SSM_CMD,
        SSM_ADDR_HI,
        SSM_ADDR_LO,
        SSM_WR_DATA,
        SSM_RD_DATA,
        SSM_IGNORE
    } ssm_phase_t;

endpackage : ssm_pkg

// ---- design/ssm_sync.sv ----
// multi-stage level synchroniser with asynchronous clear
`timescale 1ns/1ps
module ssm_sync #(
    parameter int W = 1,
    parameter int STAGES = 2
) (
    // clock and clear
    input wire logic clk_i,
    input wire logic clr_n_i,
    // data
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o,
    output logic [W-1:0] q_prev_o
);

    logic [STAGES*W-1:0] stage_reg;
    logic [STAGES*W-1:0] stage_next;

    always_comb begin
        stage_next = {stage_reg[(STAGES-1)*W-1:0], d_i};
    end

    always_ff @(posedge clk_i or negedge clr_n_i) begin
        if (!clr_n_i) begin
            stage_reg <= '0;
        end else begin
            stage_reg <= stage_next;
        end
    end

    // q_prev_o is only meaningful for three or more stages
    assign q_o = stage_reg[STAGES*W-1 -: W];
    assign q_prev_o = stage_reg[(STAGES-1)*W-1 -: W];

endmodule : ssm_sync

// ---- design/ssm_mem.sv ----
// byte-wide array with registered read data, clocked by the serial clock
`timescale 1ns/1ps
module ssm_mem (
    // clock
    input wire logic clk_i,
    // write port
    input wire logic we_i,
    input wire logic [ssm_pkg::ADDR_W-1:0] waddr_i,
    input wire logic [ssm_pkg::DATA_W-1:0] wdata_i,
    // read port
    input wire logic re_i,
    input wire logic [ssm_pkg::ADDR_W-1:0] raddr_i,
    output logic [ssm_pkg::DATA_W-1:0] rdata_o
);

    logic [ssm_pkg::DATA_W-1:0] mem [ssm_pkg::MEM_DEPTH];
    logic [ssm_pkg::DATA_W-1:0] rdata_reg;

    // array contents are nonvolatile in spirit, so no reset
    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem[waddr_i] <= wdata_i;
        end
        if (re_i) begin
            rdata_reg <= mem[raddr_i];
        end
    end

    assign rdata_o = rdata_reg;

endmodule : ssm_mem

// ---- tb/ssm_spi_mem_monitor.sv ----
// checker watching the pins of the serial memory access block
`timescale 1ns/1ps
module ssm_spi_mem_monitor (
    // watched pins
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic sck_i,
    input wire logic cs_n_i,
    input wire logic si_i,
    input wire logic hold_n_i,
    input wire logic so_oe_n_o,
    input wire logic write_latch_flag_o
);
    logic [15:0] rise_cnt;
    logic [7:0] cmd_sr;
    // rises of this frame; paused rises do not count
    always_ff @(posedge sck_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            rise_cnt <= 16'h0000;
        end else if (hold_n_i && rise_cnt != 16'hffff) begin
            rise_cnt <= rise_cnt + 16'h0001;
        end
    end
    // not cleared at frame end so the clock side can still read it
    always_ff @(posedge sck_i) begin
        if (!cs_n_i && hold_n_i && rise_cnt < 16'h0008) begin
            cmd_sr <= {cmd_sr[6:0], si_i};
        end
    end
    a_oe_idle_float: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        cs_n_i || !hold_n_i |-> so_oe_n_o) else $error("output not floating");
    a_oe_new_frame: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        $fell(cs_n_i) |-> so_oe_n_o) else $error("new frame starts driving");
    a_oe_read_data: assert property (
        @(posedge sck_i) disable iff (cs_n_i)
        hold_n_i && cmd_sr == ssm_pkg::CMD_READ && rise_cnt >= 16'h0018
        |-> !so_oe_n_o) else $error("read data not driven");
    a_oe_before_data: assert property (
        @(posedge sck_i) disable iff (cs_n_i)
        rise_cnt < 16'h0018 |-> so_oe_n_o) else $error("driven too early");
    a_oe_other_cmd: assert property (
        @(posedge sck_i) disable iff (cs_n_i)
        rise_cnt >= 16'h0008 && cmd_sr != ssm_pkg::CMD_READ |-> so_oe_n_o)
        else $error("driven outside a read");
    a_latch_set: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        $rose(cs_n_i) && cmd_sr == ssm_pkg::CMD_SET_WRITE_LATCH
        |-> ##[1:12] write_latch_flag_o) else $error("latch not set");
    a_latch_clear: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        $rose(cs_n_i) && cmd_sr == ssm_pkg::CMD_WRITE
        |-> ##[1:12] !write_latch_flag_o) else $error("latch not cleared");
    a_latch_in_frame: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        !cs_n_i && !$past(cs_n_i) |-> $stable(write_latch_flag_o))
        else $error("latch moved inside a frame");
endmodule : ssm_spi_mem_monitor
bind ssm_spi_mem ssm_spi_mem_monitor ssm_spi_mem_monitor_inst (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .sck_i(sck_i),
    .cs_n_i(cs_n_i),
    .si_i(si_i),
    .hold_n_i(hold_n_i),
    .so_oe_n_o(so_oe_n_o),
    .write_latch_flag_o(write_latch_flag_o)
);

// ---- tb/ssm_master.sv ----
// serial bus master model driving the link pins
`timescale 1ns/1ps
module ssm_master (
    // link pins
    output logic sck_o,
    output logic cs_n_o,
    output logic si_o,
    output logic hold_n_o,
    input wire logic so_i
);
    // clock stands low outside frames
    initial begin
        sck_o = 1'b0;
        cs_n_o = 1'b1;
        si_o = 1'b0;
        hold_n_o = 1'b1;
    end
    task automatic start_f();
        cs_n_o = 1'b0;
        #10;
    endtask : start_f
    // deselect gap covers the latch crossing
    task automatic end_f();
        #3;
        cs_n_o = 1'b1;
        si_o = ~si_o;
        #60;
    endtask : end_f
    // msb first; pause after bit p when p < 8
    task automatic xfer(input logic [7:0] tx, input int p,
                        output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            si_o = tx[i];
            #3 sck_o = 1'b1;
            rx[i] = so_i;
            #3 sck_o = 1'b0;
            if (7 - i == p) begin
                #1 hold_n_o = 1'b0;
                si_o = ~si_o;
                repeat (3) begin
                    #3 sck_o = 1'b1;
                    #3 sck_o = 1'b0;
                end
                #1 hold_n_o = 1'b1;
            end
        end
    endtask : xfer
    // half a byte, to be dropped by the device
    task automatic stub();
        repeat (4) begin
            si_o = 1'b1;
            #3 sck_o = 1'b1;
            #3 sck_o = 1'b0;
        end
    endtask : stub
endmodule : ssm_master

// ---- tb/ssm_spi_mem_test.sv ----
// testbench for the serial memory access block
`timescale 1ns/1ps
module ssm_spi_mem_test;
    logic clk, rst_n, sck, cs_n, si, hold_n, wp_n, so, so_oe_n;
    logic bp_hi, bp_lo, latch, so_bus;
    int error_cnt, checks_done, cycles;
    ssm_spi_mem ssm_spi_mem_inst (
        .clk_i(clk), .rst_n_i(rst_n), .sck_i(sck), .cs_n_i(cs_n),
        .si_i(si), .hold_n_i(hold_n), .wp_n_i(wp_n), .so_o(so),
        .so_oe_n_o(so_oe_n), .block_protect_hi_i(bp_hi),
        .block_protect_lo_i(bp_lo), .write_latch_flag_o(latch));
    ssm_master ssm_master_inst (.sck_o(sck), .cs_n_o(cs_n), .si_o(si),
        .hold_n_o(hold_n), .so_i(so_bus));
    // a released line reads inverted, so a late or early enable shows up
    assign so_bus = so_oe_n ? ~so : so;
    always #2.5 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            $display("unexpected at %0t: run too long", $time);
            results();
        end
    end
    task automatic results();
        if (error_cnt == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : results
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    function automatic logic [7:0] pat(input logic [14:0] a,
                                       input logic [7:0] k);
        return a[7:0] ^ {1'b0, a[14:8]} ^ k;
    endfunction : pat
    task automatic pins(input logic w, input logic [1:0] bp);
        @(posedge clk);
        #1 wp_n = w;
        {bp_hi, bp_lo} = bp;
    endtask : pins
    task automatic set_write_latch_cmd();
        logic [7:0] rx;
        ssm_master_inst.start_f();
        ssm_master_inst.xfer(ssm_pkg::CMD_SET_WRITE_LATCH, 8, rx);
        ssm_master_inst.end_f();
    endtask : set_write_latch_cmd
    // top address bit set on purpose; second data byte paused mid-way
    task automatic wr(input logic [14:0] a, input logic [7:0] k,
                      input int n, input int tail);
        logic [7:0] rx;
        logic [14:0] b;
        b = a;
        ssm_master_inst.start_f();
        ssm_master_inst.xfer(ssm_pkg::CMD_WRITE, 8, rx);
        ssm_master_inst.xfer({1'b1, a[14:8]}, 8, rx);
        ssm_master_inst.xfer(a[7:0], 8, rx);
        for (int i = 0; i < n; i++) begin
            ssm_master_inst.xfer(pat(b, k), i == 1 ? 3 : 8, rx);
            b++;
        end
        if (tail != 0) begin
            ssm_master_inst.stub();
        end
        ssm_master_inst.end_f();
    endtask : wr
    // junk on the data input while reading must not matter
    task automatic rd(input logic [14:0] a, input logic [7:0] k, input int n);
        logic [7:0] rx;
        logic [14:0] b;
        b = a;
        ssm_master_inst.start_f();
        ssm_master_inst.xfer(ssm_pkg::CMD_READ, 8, rx);
        ssm_master_inst.xfer({1'b1, a[14:8]}, 8, rx);
        ssm_master_inst.xfer(a[7:0], 8, rx);
        for (int i = 0; i < n; i++) begin
            ssm_master_inst.xfer(8'ha5, i == 1 ? 4 : 8, rx);
            chk(rx, pat(b, k));
            b++;
        end
        ssm_master_inst.end_f();
    endtask : rd
    task automatic t_seq();
        set_write_latch_cmd();
        chk({7'h00, latch}, 8'h01);
        wr(15'h7ffe, 8'h11, 4, 0);
        chk({7'h00, latch}, 8'h00);
        rd(15'h7ffe, 8'h11, 4);
        wr(15'h7ffe, 8'h22, 2, 0);
        rd(15'h7ffe, 8'h11, 2);
    endtask : t_seq
    task automatic t_partial();
        set_write_latch_cmd();
        wr(15'h0010, 8'h33, 2, 1);
        set_write_latch_cmd();
        wr(15'h0010, 8'h44, 1, 1);
        rd(15'h0010, 8'h44, 1);
        rd(15'h0011, 8'h33, 1);
    endtask : t_partial
    task automatic t_wp();
        pins(1'b0, 2'h0);
        set_write_latch_cmd();
        wr(15'h0010, 8'h55, 1, 0);
        pins(1'b1, 2'h0);
        rd(15'h0010, 8'h44, 1);
        set_write_latch_cmd();
        fork
            wr(15'h0020, 8'h66, 3, 0);
            begin
                #150;
                pins(1'b0, 2'h0);
            end
        join
        pins(1'b1, 2'h0);
        rd(15'h0020, 8'h66, 3);
    endtask : t_wp
    // last byte below the quarter and half bases, then the base itself; for all, the top byte then zero
    task automatic t_prot();
        logic [14:0] b;
        for (int m = 1; m < 4; m++) begin
            b = (m == 1) ? 15'h5fff : (m == 2) ? 15'h3fff : 15'h7fff;
            pins(1'b1, 2'h0);
            set_write_latch_cmd();
            wr(b, 8'h60, 2, 0);
            pins(1'b1, m[1:0]);
            set_write_latch_cmd();
            wr(b, 8'h70, 2, 0);
            rd(b, m == 3 ? 8'h60 : 8'h70, 1);
            rd(b + 15'h0001, 8'h60, 1);
        end
        pins(1'b1, 2'h0);
    endtask : t_prot
    // an unknown command leaves the latch alone and the rest is ignored
    task automatic t_unknown();
        logic [7:0] rx;
        set_write_latch_cmd();
        ssm_master_inst.start_f();
        ssm_master_inst.xfer(8'h0a, 8, rx);
        ssm_master_inst.xfer(ssm_pkg::CMD_WRITE, 8, rx);
        ssm_master_inst.end_f();
        chk({7'h00, latch}, 8'h01);
        wr(15'h0030, 8'h77, 1, 0);
        rd(15'h0030, 8'h77, 1);
    endtask : t_unknown
    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        wp_n = 1'b1;
        bp_hi = 1'b0;
        bp_lo = 1'b0;
        error_cnt = 0;
        checks_done = 0;
        cycles = 0;
        repeat (6) @(posedge clk);
        #1 rst_n = 1'b1;
        repeat (10) @(posedge clk);
        t_seq();
        t_partial();
        t_wp();
        t_prot();
        t_unknown();
        results();
    end
endmodule : ssm_spi_mem_test
